// *** design/crp_profiler.sv ***
`timescale 1ns/100ps
// Function
// R1: Source code 10b selects the digital command
// R2: Profile 00b passes command straight through
// R3: Profile 01b applies linear profile
// R4: Profile 10b applies staircase profile
// R5: Profile 11b applies forward-reverse profile
// R6: Forward-reverse reverses direction at breakpoint C
// R7: Speed target is level/255 times max speed
// R8: Power target is level/255 times max power
// R9: Current target is level/255 times current limit
// R10: Voltage target is level/255 of full index
// R11: Bypass ignores changes below command hysteresis
// R12: Sleep device stops on zero command
// R13: Standby device runs low-off reference on zero
// R14: Low-off region with off/on hysteresis
// R15: Lower clamp reference up to lower breakpoint
// R16: Linear interpolation between successive breakpoints
// R17: Upper clamp reference up to high-off
// R18: High-off region with off/on hysteresis
// R19: Staircase steps at each breakpoint
// R20: Staircase steps use command hysteresis
// R21: Controller programs breakpoints in ascending order
// R22: Forward-reverse ignores direction pin and override
// R23: Level below 1 percent forces stop
// R24: Forward-reverse off between breakpoints B and D
// R25: Outputs change together, no intermediate values
module crp_profiler
    import crp_pkg::*;
#(
    parameter int FS_W = 16
)
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // Duty command sources
    input  wire logic [7:0]            duty_pin,
    input  wire logic [7:0]            duty_digital,
    input  wire logic [1:0]            source_sel,
    // Mode selection
    input  wire logic [1:0]            profile_sel,
    input  wire logic [1:0]            ctrl_mode,
    input  wire logic                  sleep_device,
    // Profile thresholds and references
    input  wire logic [7:0]            command_hysteresis,
    input  wire logic [7:0]            low_off_threshold,
    input  wire logic [7:0]            low_on_threshold,
    input  wire logic [7:0]            low_off_reference,
    input  wire logic [7:0]            lower_clamp_breakpoint,
    input  wire logic [7:0]            lower_clamp_reference,
    input  wire logic [4:0][7:0]       bp_duty,
    input  wire logic [4:0][7:0]       bp_ref,
    input  wire logic [7:0]            upper_clamp_breakpoint,
    input  wire logic [7:0]            upper_clamp_reference,
    input  wire logic [7:0]            high_off_threshold,
    input  wire logic [7:0]            high_on_threshold,
    input  wire logic [7:0]            high_off_reference,
    // Full scale values
    input  wire logic [FS_W-1:0]       max_speed,
    input  wire logic [FS_W-1:0]       max_power,
    input  wire logic [FS_W-1:0]       current_full_scale,
    // Direction inputs
    input  wire logic                  dir_pin,
    input  wire logic                  dir_override_en,
    input  wire logic                  dir_override_val,
    // Outputs to the control loops
    output logic      [7:0]            ref_level_q,
    output logic      [FS_W-1:0]       target_ref_q,
    output logic                       direction_q,
    output logic                       motor_stop_q,
    output logic                       ref_update_q
);
    // Selected duty command
    logic [7:0]       duty_sel;
    // Knots: 0 lower clamp, 1..5 A..E, 6 upper clamp
    logic [6:0][7:0]  kd;
    logic [6:0][7:0]  kr;
    // Hysteresis state
    logic             low_off_q;
    logic             high_off_q;
    logic [7:0]       held_q;
    logic [2:0]       step_q;
    // First stage results
    logic [7:0]       ref_x_d;
    logic [7:0]       ref_x_q;
    logic             stop_x_d;
    logic             stop_x_q;
    logic             dir_x_d;
    logic             dir_x_q;
    // Interpolation segment
    logic [7:0]       seg_d0;
    logic [7:0]       seg_d1;
    logic [7:0]       seg_r0;
    logic [7:0]       seg_r1;
    logic [7:0]       seg_span;
    logic [7:0]       seg_y;
    logic [7:0]       lin_ref;
    // Scaling
    logic [FS_W-1:0]  full_scale;
    logic [FS_W-1:0]  scaled;
    // Bypass change size and staircase lower edge
    logic [7:0]       held_diff;
    logic [8:0]       down_edge;

    generate
        if (FS_W < CRP_DUTY_W)
        begin : g_bad_fs
            $error("FS_W must be at least the command width");
        end
    endgenerate

    // R1: digital source select
    assign duty_sel = (source_sel == CRP_SRC_DIGITAL) ? duty_digital : duty_pin;

    assign kd = {upper_clamp_breakpoint, bp_duty, lower_clamp_breakpoint};
    assign kr = {upper_clamp_reference, bp_ref, lower_clamp_reference};

    // R14: low-off hysteresis
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            low_off_q <= 1'b0;
        else if (duty_sel < low_off_threshold)
            low_off_q <= 1'b1;
        else if (duty_sel >= low_on_threshold)
            low_off_q <= 1'b0;
    end

    // R18: high-off hysteresis
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            high_off_q <= 1'b0;
        else if (duty_sel > high_off_threshold)
            high_off_q <= 1'b1;
        else if (duty_sel < high_on_threshold)
            high_off_q <= 1'b0;
    end

    // Size of change from the held command
    assign held_diff = (duty_sel >= held_q) ? duty_sel - held_q : held_q - duty_sel;

    // R11: bypass command follows only changes of at least the hysteresis
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            held_q <= CRP_RST_LEVEL;
        else if (held_diff >= command_hysteresis)
            held_q <= duty_sel;
    end

    // Command raised by the hysteresis, compared with the breakpoint below the current step
    assign down_edge = {1'b0, duty_sel} + {1'b0, command_hysteresis};

    // R19: one step per cycle toward the command
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            step_q <= CRP_RST_STEP;
        else if (step_q != CRP_TOP_STEP && duty_sel > kd[step_q])
            step_q <= step_q + 3'h1;
        // R20: step down only at or below the edge less hysteresis
        else if (step_q != CRP_RST_STEP && down_edge <= {1'b0, kd[step_q - 3'h1]})
            step_q <= step_q - 3'h1;
    end

    // Segment choice for the interpolator
    always_comb
    begin
        seg_d0 = kd[0];
        seg_d1 = kd[1];
        seg_r0 = kr[0];
        seg_r1 = kr[1];
        if (profile_sel == CRP_PROF_FWDREV)
        begin
            // Reverse ramp runs from reference D to the upper clamp
            if (duty_sel > kd[1])
            begin
                seg_d0 = kd[5];
                seg_d1 = kd[6];
                seg_r0 = kr[4];
                seg_r1 = kr[6];
            end
        end
        else
        begin
            // R16: segment whose lower knot lies below the command
            for (int i = 1; i < 6; i++)
            begin
                if (duty_sel > kd[i])
                begin
                    seg_d0 = kd[i];
                    seg_d1 = kd[i+1];
                    seg_r0 = kr[i];
                    seg_r1 = kr[i+1];
                end
            end
        end
    end

    assign seg_span = seg_d1 - seg_d0;

    // Fraction of the reference change across the segment
    crp_ratio #(
        .AW (8),
        .BW (8)
    ) u_interp (
        .a (seg_r1 >= seg_r0 ? seg_r1 - seg_r0 : seg_r0 - seg_r1),
        .b (duty_sel - seg_d0),
        .c (seg_span),
        .y (seg_y)
    );

    // R16: interpolated level, rising or falling
    assign lin_ref = (seg_r1 >= seg_r0) ? seg_r0 + seg_y : seg_r0 - seg_y;

    // Profile level, stop and direction
    always_comb
    begin
        ref_x_d = lin_ref;
        stop_x_d = 1'b0;
        dir_x_d = dir_override_en ? dir_override_val : dir_pin;
        unique case (profile_sel)
            // R2: held command used as the level
            CRP_PROF_BYPASS:
            begin
                ref_x_d = held_q;
            end
            // R3: linear profile
            CRP_PROF_LINEAR:
            begin
                // R15: lower clamp hold
                if (duty_sel <= kd[0])
                    ref_x_d = kr[0];
                // R17: upper clamp hold
                else if (duty_sel > kd[6])
                    ref_x_d = kr[6];
            end
            // R4: staircase level from the step index
            CRP_PROF_STAIR:
            begin
                ref_x_d = kr[step_q];
            end
            // R5: forward-reverse profile
            CRP_PROF_FWDREV:
            begin
                // R22: direction from the command alone
                // R6: reverse from breakpoint C upward
                dir_x_d = (duty_sel < kd[3]);
                if (duty_sel <= kd[0])
                    ref_x_d = kr[0];
                else if (duty_sel <= kd[1])
                    ref_x_d = lin_ref;
                else if (duty_sel <= kd[2])
                    ref_x_d = kr[1];
                // R24: off between B and D
                else if (duty_sel <= kd[4])
                begin
                    ref_x_d = CRP_RST_LEVEL;
                    stop_x_d = 1'b1;
                end
                else if (duty_sel <= kd[5])
                    ref_x_d = kr[4];
                else if (duty_sel > kd[6])
                    ref_x_d = kr[6];
            end
        endcase
        if (profile_sel != CRP_PROF_BYPASS)
        begin
            // R14: low-off reference
            if (low_off_q)
                ref_x_d = low_off_reference;
            // R18: high-off reference
            if (high_off_q)
                ref_x_d = high_off_reference;
            if (duty_sel == CRP_RST_LEVEL)
            begin
                // R12: sleep device stops, R13: standby runs low-off level
                ref_x_d = sleep_device ? CRP_RST_LEVEL : low_off_reference;
            end
        end
        // R23: below 1 percent clamps to zero and stops
        if (ref_x_d < CRP_MIN_LEVEL)
        begin
            ref_x_d = CRP_RST_LEVEL;
            stop_x_d = 1'b1;
        end
    end

    // First stage register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ref_x_q <= CRP_RST_LEVEL;
            stop_x_q <= 1'b1;
            dir_x_q <= 1'b1;
        end
        else
        begin
            ref_x_q <= ref_x_d;
            stop_x_q <= stop_x_d;
            dir_x_q <= dir_x_d;
        end
    end

    // Full scale by control mode
    always_comb
    begin
        unique case (ctrl_mode)
            // R7: speed
            CRP_MODE_SPEED:   full_scale = max_speed;
            // R8: power
            CRP_MODE_POWER:   full_scale = max_power;
            // R9: current
            CRP_MODE_CURRENT: full_scale = current_full_scale;
            // R10: modulation index
            CRP_MODE_VOLTAGE: full_scale = FS_W'(CRP_MOD_FULL);
        endcase
    end

    // Level over 255 times full scale
    crp_ratio #(
        .AW (FS_W),
        .BW (8)
    ) u_scale (
        .a (full_scale),
        .b (ref_x_q),
        .c (CRP_REF_FULL),
        .y (scaled)
    );

    // R25: all outputs load on the same edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ref_level_q <= CRP_RST_LEVEL;
            target_ref_q <= '0;
            direction_q <= 1'b1;
            motor_stop_q <= 1'b1;
            ref_update_q <= 1'b0;
        end
        else
        begin
            ref_level_q <= ref_x_q;
            target_ref_q <= stop_x_q ? '0 : scaled;
            direction_q <= dir_x_q;
            motor_stop_q <= stop_x_q;
            ref_update_q <= (ref_x_q != ref_level_q) || (stop_x_q != motor_stop_q);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_stop_zero;
        motor_stop_q |-> target_ref_q == '0;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("stop with nonzero target"); // R23

    property p_bypass;
        profile_sel == CRP_PROF_BYPASS && command_hysteresis == 8'h00
            |=> held_q == $past(duty_sel);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass lost command"); // R2

    property p_hys_hold;
        held_diff < command_hysteresis |=> $stable(held_q);
    endproperty
    a_hys_hold: assert property (p_hys_hold) else $error("small change moved held"); // R11

    property p_dir_override;
        profile_sel != CRP_PROF_FWDREV && dir_override_en
            |=> dir_x_q == $past(dir_override_val) ##1 direction_q == $past(dir_x_q);
    endproperty
    a_dir_override: assert property (p_dir_override) else $error("override ignored"); // R22

    property p_fr_reverse;
        profile_sel == CRP_PROF_FWDREV && duty_sel >= kd[3] |-> ##2 !direction_q;
    endproperty
    a_fr_reverse: assert property (p_fr_reverse) else $error("no reverse at C"); // R6

    property p_sleep_zero;
        profile_sel != CRP_PROF_BYPASS && sleep_device && duty_sel == 8'h00
            |-> ##2 motor_stop_q && target_ref_q == '0;
    endproperty
    a_sleep_zero: assert property (p_sleep_zero) else $error("sleep zero ran"); // R12

    property p_standby_zero;
        profile_sel != CRP_PROF_BYPASS && !sleep_device && duty_sel == 8'h00
            && low_off_reference >= CRP_MIN_LEVEL |=> ref_x_q == $past(low_off_reference);
    endproperty
    a_standby_zero: assert property (p_standby_zero) else $error("standby level wrong"); // R13

    property p_speed_scale;
        ctrl_mode == CRP_MODE_SPEED && !stop_x_q
            |=> target_ref_q == FS_W'(($past(max_speed) * $past(ref_x_q)) / 255);
    endproperty
    a_speed_scale: assert property (p_speed_scale) else $error("speed scaling wrong"); // R7

    property p_stair_hold;
        profile_sel == CRP_PROF_STAIR && step_q != 3'h0 && step_q != CRP_TOP_STEP
            && duty_sel <= kd[step_q] && down_edge > {1'b0, kd[step_q - 3'h1]}
            |=> $stable(step_q);
    endproperty
    a_stair_hold: assert property (p_stair_hold) else $error("step moved in band"); // R20

    property p_fr_off;
        profile_sel == CRP_PROF_FWDREV && duty_sel > kd[2] && duty_sel <= kd[4]
            && !low_off_q && !high_off_q && duty_sel != 8'h00 |-> ##2 motor_stop_q;
    endproperty
    a_fr_off: assert property (p_fr_off) else $error("not off between B and D"); // R24

    c_step_up: cover property (profile_sel == CRP_PROF_STAIR ##1 step_q == CRP_TOP_STEP);
    c_fr_rev: cover property (profile_sel == CRP_PROF_FWDREV && !direction_q && !motor_stop_q);
    c_high_off: cover property (high_off_q ##2 ref_level_q == high_off_reference);
endmodule

// *** design/crp_pkg.sv ***
package crp_pkg;
    // Command and reference width, full scale 255
    localparam int          CRP_DUTY_W       = 8;
    // Duty command source select codes
    localparam logic [1:0]  CRP_SRC_DIGITAL  = 2'h2;
    // Profile select codes
    localparam logic [1:0]  CRP_PROF_BYPASS  = 2'h0;
    localparam logic [1:0]  CRP_PROF_LINEAR  = 2'h1;
    localparam logic [1:0]  CRP_PROF_STAIR   = 2'h2;
    localparam logic [1:0]  CRP_PROF_FWDREV  = 2'h3;
    // Control loop mode codes
    localparam logic [1:0]  CRP_MODE_SPEED   = 2'h0;
    localparam logic [1:0]  CRP_MODE_POWER   = 2'h1;
    localparam logic [1:0]  CRP_MODE_CURRENT = 2'h2;
    localparam logic [1:0]  CRP_MODE_VOLTAGE = 2'h3;
    // Divisor of the scaling step
    localparam logic [7:0]  CRP_REF_FULL     = 8'hFF;
    // Smallest level at or above 1 percent of 255
    localparam logic [7:0]  CRP_MIN_LEVEL    = 8'h03;
    // Full modulation index on the target output
    localparam logic [15:0] CRP_MOD_FULL     = 16'hFFFF;
    // Reset values
    localparam logic [7:0]  CRP_RST_LEVEL    = 8'h00;
    localparam logic [2:0]  CRP_RST_STEP     = 3'h0;
    // Index of the last staircase step (upper clamp)
    localparam logic [2:0]  CRP_TOP_STEP     = 3'h6;
endpackage

// *** design/crp_ratio.sv ***
`timescale 1ns/100ps
// Unsigned y = a * b / c, zero when c is zero; y never exceeds a when b <= c
module crp_ratio
    import crp_pkg::*;
#(
    parameter int AW = 16,
    parameter int BW = 8
)
(
    // Operands
    input  wire logic [AW-1:0] a,
    input  wire logic [BW-1:0] b,
    input  wire logic [BW-1:0] c,
    // Result
    output logic      [AW-1:0] y
);
    // Full width product
    logic [AW+BW-1:0] prod;

    generate
        if (AW < 1 || BW < 1)
        begin : g_bad
            $error("crp_ratio widths must be positive");
        end
    endgenerate

    // Product and quotient, cut back to the result width
    always_comb
    begin
        prod = a * b;
        if (c == '0)
        begin
            y = '0;
        end
        else
        begin
            y = AW'(prod / (AW+BW)'(c));
        end
    end
endmodule

// *** dv/crp_host_model.sv ***
`timescale 1ns/100ps
// Host controller that writes the digital duty command
module crp_host_model
    import crp_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Command written over the serial bus
    output logic      [7:0] duty_digital
);
    // Last written command, held until the next write
    initial duty_digital = 8'h00;

    task automatic put(input logic [7:0] value);
        duty_digital = value;
    endtask
endmodule

// *** dv/test_crp_profiler.sv ***
`timescale 1ns/100ps
// Self-checking bench: settled behavioural model against the profiler
module test_crp_profiler
    import crp_pkg::*;
;
    // Time limit: 8 runs of about 150 samples, 13 cycles each, with margin
    localparam int WATCH = 8 * 150 * 13 * 3;
    // Design inputs
    logic            sys_clk;
    logic            nrst;
    logic [7:0]      duty_pin;
    logic [7:0]      duty_digital;
    logic [1:0]      source_sel;
    logic [1:0]      profile_sel;
    logic [1:0]      ctrl_mode;
    logic            sleep_device;
    logic [7:0]      command_hysteresis;
    logic [7:0]      low_off_threshold;
    logic [7:0]      low_on_threshold;
    logic [7:0]      low_off_reference;
    logic [7:0]      lower_clamp_breakpoint;
    logic [7:0]      lower_clamp_reference;
    logic [4:0][7:0] bp_duty;
    logic [4:0][7:0] bp_ref;
    logic [7:0]      upper_clamp_breakpoint;
    logic [7:0]      upper_clamp_reference;
    logic [7:0]      high_off_threshold;
    logic [7:0]      high_on_threshold;
    logic [7:0]      high_off_reference;
    logic [15:0]     max_speed;
    logic [15:0]     max_power;
    logic [15:0]     current_full_scale;
    logic            dir_pin;
    logic            dir_override_en;
    logic            dir_override_val;
    // Design outputs
    logic [7:0]      ref_level_q;
    logic [15:0]     target_ref_q;
    logic            direction_q;
    logic            motor_stop_q;
    logic            ref_update_q;
    // Bench state
    logic [15:0]     lfsr_q = 16'h0009;
    int              kd [7];
    int              kr [7];
    int              m_held;
    int              m_lo;
    int              m_hi;
    int              m_step;
    int              m_lvl;
    int              m_stp;
    int              mismatches = 0;
    int              comparisons = 0;

    // Device under test
    crp_profiler #(.FS_W(16)) u_crp_profiler (
        .sys_clk(sys_clk), .nrst(nrst), .duty_pin(duty_pin), .duty_digital(duty_digital),
        .source_sel(source_sel), .profile_sel(profile_sel), .ctrl_mode(ctrl_mode),
        .sleep_device(sleep_device), .command_hysteresis(command_hysteresis),
        .low_off_threshold(low_off_threshold), .low_on_threshold(low_on_threshold),
        .low_off_reference(low_off_reference), .lower_clamp_breakpoint(lower_clamp_breakpoint),
        .lower_clamp_reference(lower_clamp_reference), .bp_duty(bp_duty), .bp_ref(bp_ref),
        .upper_clamp_breakpoint(upper_clamp_breakpoint),
        .upper_clamp_reference(upper_clamp_reference), .high_off_threshold(high_off_threshold),
        .high_on_threshold(high_on_threshold), .high_off_reference(high_off_reference),
        .max_speed(max_speed), .max_power(max_power), .current_full_scale(current_full_scale),
        .dir_pin(dir_pin), .dir_override_en(dir_override_en), .dir_override_val(dir_override_val),
        .ref_level_q(ref_level_q), .target_ref_q(target_ref_q), .direction_q(direction_q),
        .motor_stop_q(motor_stop_q), .ref_update_q(ref_update_q)
    );

    // Far-side controller
    crp_host_model u_crp_host_model (.sys_clk(sys_clk), .duty_digital(duty_digital));

    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Pseudo-random source
    function automatic int rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return int'(lfsr_q);
    endfunction

    // Random duty, zero one time in sixteen
    function automatic int rduty();
        int r;
        r = rnd();
        return ((r & 15) == 0) ? 0 : (r >> 8) & 255;
    endfunction

    // Interpolation between two knots, floor of the offset
    function automatic int interp(int d, int d0, int r0, int d1, int r1);
        if (d1 == d0)
            return r0;
        if (r1 >= r0)
            return r0 + (r1 - r0) * (d - d0) / (d1 - d0);
        return r0 - (r0 - r1) * (d - d0) / (d1 - d0);
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Random configuration
    task automatic configure();
        // ascending breakpoints, clamps inside off thresholds
        for (int i = 0; i < 7; i++)
        begin
            kd[i] = 40 + 28 * i + (rnd() & 7);
            kr[i] = rnd() & 255;
        end
        lower_clamp_breakpoint = 8'(kd[0]);
        lower_clamp_reference = 8'(kr[0]);
        for (int i = 0; i < 5; i++)
        begin
            bp_duty[i] = 8'(kd[i + 1]);
            bp_ref[i] = 8'(kr[i + 1]);
        end
        upper_clamp_breakpoint = 8'(kd[6]);
        upper_clamp_reference = 8'(kr[6]);
        low_off_threshold = 8'(20 + (rnd() & 7));
        low_on_threshold = low_off_threshold + 8'h08;
        high_off_threshold = 8'(236 + (rnd() & 7));
        high_on_threshold = high_off_threshold - 8'h0A;
        low_off_reference = 8'(rnd());
        high_off_reference = 8'(rnd());
        command_hysteresis = 8'(rnd() & 7);
        max_speed = 16'(rnd());
        max_power = 16'(rnd());
        current_full_scale = 16'(rnd());
    endtask

    // Settled model of the outputs for the present inputs
    task automatic model(output int lvl, output int tgt, output int dir, output int stp);
        int d;
        int fs;
        int hys;
        d = (source_sel == CRP_SRC_DIGITAL) ? int'(duty_digital) : int'(duty_pin);
        hys = int'(command_hysteresis);
        if (hys == 0 || d - m_held >= hys || m_held - d >= hys)
            m_held = d;
        if (d < int'(low_off_threshold))
            m_lo = 1;
        else if (d >= int'(low_on_threshold))
            m_lo = 0;
        if (d > int'(high_off_threshold))
            m_hi = 1;
        else if (d < int'(high_on_threshold))
            m_hi = 0;
        forever
        begin
            if (m_step < 6 && d > kd[m_step])
                m_step++;
            else if (m_step > 0 && d + hys <= kd[m_step - 1])
                m_step--;
            else
                break;
        end
        if (profile_sel == CRP_PROF_BYPASS)
            lvl = m_held;
        else if (d == 0)
            lvl = sleep_device ? 0 : int'(low_off_reference);
        else if (m_hi != 0)
            lvl = int'(high_off_reference);
        else if (m_lo != 0)
            lvl = int'(low_off_reference);
        else if (profile_sel == CRP_PROF_STAIR)
            lvl = kr[m_step];
        else if (profile_sel == CRP_PROF_LINEAR)
        begin
            lvl = kr[6];
            for (int k = 5; k >= 0; k--)
                if (d <= kd[k + 1])
                    lvl = interp(d, kd[k], kr[k], kd[k + 1], kr[k + 1]);
            if (d <= kd[0])
                lvl = kr[0];
        end
        else if (d <= kd[0])
            lvl = kr[0];
        else if (d <= kd[1])
            lvl = interp(d, kd[0], kr[0], kd[1], kr[1]);
        else if (d <= kd[2])
            lvl = kr[1];
        else if (d <= kd[4])
            lvl = 0;
        else if (d <= kd[5])
            lvl = kr[4];
        else if (d <= kd[6])
            lvl = interp(d, kd[5], kr[4], kd[6], kr[6]);
        else
            lvl = kr[6];
        case (ctrl_mode)
            CRP_MODE_SPEED:   fs = int'(max_speed);
            CRP_MODE_POWER:   fs = int'(max_power);
            CRP_MODE_CURRENT: fs = int'(current_full_scale);
            default:          fs = int'(CRP_MOD_FULL);
        endcase
        // Below 1 percent the level itself is forced to zero
        stp = (lvl < int'(CRP_MIN_LEVEL)) ? 1 : 0;
        lvl = (stp != 0) ? 0 : lvl;
        tgt = lvl * fs / 255;
        if (profile_sel == CRP_PROF_FWDREV)
            dir = (d < kd[3]) ? 1 : 0;
        else
            dir = dir_override_en ? int'(dir_override_val) : int'(dir_pin);
    endtask

    // Reset pulse with reset-value checks
    task automatic do_reset();
        @(posedge sys_clk);
        #1;
        nrst = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        check(ref_level_q, 32'h0);
        check(target_ref_q, 32'h0);
        check(direction_q, 32'h1);
        check(motor_stop_q, 32'h1);
        check(ref_update_q, 32'h0);
        nrst = 1'b1;
        m_held = 0;
        m_lo = 0;
        m_hi = 0;
        m_step = 0;
        m_lvl = 0;
        m_stp = 1;
    endtask

    // Drive one sample, let it settle, compare with the model
    task automatic apply(input int dp, input int dd);
        logic [15:0] r;
        int          lvl;
        int          tgt;
        int          dir;
        int          stp;
        int          pulses;
        @(posedge sys_clk);
        #1;
        r = 16'(rnd());
        duty_pin = 8'(dp);
        u_crp_host_model.put(8'(dd));
        source_sel = r[1:0];
        ctrl_mode = r[3:2];
        sleep_device = r[4];
        dir_pin = r[5];
        dir_override_en = r[6];
        dir_override_val = r[7];
        pulses = 0;
        repeat (12)
        begin
            @(posedge sys_clk);
            #1;
            pulses += int'(ref_update_q);
        end
        model(lvl, tgt, dir, stp);
        check(ref_level_q, lvl);
        check(target_ref_q, tgt);
        check(direction_q, dir);
        check(motor_stop_q, stp);
        check(ref_update_q, 32'h0);
        // Any settled change of level or stop must have raised an update pulse
        if (lvl != m_lvl || stp != m_stp)
            check(32'(pulses != 0), 32'h1);
        m_lvl = lvl;
        m_stp = stp;
    endtask

    // Main sequence: every profile, two configurations, sweeps and random
    initial
    begin
        nrst = 1'b0;
        duty_pin = 8'h00;
        source_sel = 2'h0;
        profile_sel = 2'h0;
        ctrl_mode = 2'h0;
        sleep_device = 1'b0;
        dir_pin = 1'b0;
        dir_override_en = 1'b0;
        dir_override_val = 1'b0;
        configure();
        for (int p = 0; p < 4; p++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                configure();
                // First setting of each profile runs without hysteresis
                if (c == 0)
                    command_hysteresis = 8'h00;
                profile_sel = 2'(p);
                do_reset();
                // Sweep up then down across every breakpoint
                for (int d = 0; d < 256; d += 5)
                    apply(d, d);
                for (int d = 255; d >= 0; d -= 5)
                    apply(d, d);
                // Random jumps, independent sources
                repeat (30)
                    apply(rduty(), rduty());
            end
        end
        summarize();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (WATCH) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
endmodule
